// [common/fcm_consts.svh]
// Register offsets, field positions, reset values and timing counts of the clock monitor
// Assumes a 32-bit APB register bus with byte addresses
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

`define FCM_OFF_CTRL       8'h00
`define FCM_OFF_STATUS     8'h04
`define FCM_OFF_MASK       8'h08
`define FCM_OFF_STATE      8'h0c

`define FCM_CTRL_MODE_LSB  0
`define FCM_CTRL_SEL_LSB   4
`define FCM_STAT_FAIL      0
`define FCM_STAT_READY     1
`define FCM_STAT_W         2

`define FCM_CTRL_RESET     32'h0000_0000
`define FCM_MASK_RESET     2'h0

`define FCM_SAMPLE_EDGES   4

`endif

// [common/fcm_pkg.sv]
// Types shared by the clock monitor modules
// Assumes nothing beyond a SystemVerilog compiler
package fcm_pkg;

  typedef enum logic [2:0] {
    MD_EXTERNAL_CLOCK  = 3'h0,
    MD_EXTERNAL_RC     = 3'h1,
    MD_INTERNAL_RC     = 3'h2,
    MD_LOW_POWER_XTAL  = 3'h3,
    MD_STANDARD_XTAL   = 3'h4,
    MD_HIGH_SPEED_XTAL = 3'h5,
    MD_HIGH_SPEED_PLL  = 3'h6,
    MD_UNUSED          = 3'h7
  } fcm_mode_t;

  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL  = 2'h2,
    SRC_SPARE     = 2'h3
  } fcm_src_t;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'h0,
    ST_START = 2'h1,
    ST_RUN   = 2'h3,
    ST_FAIL  = 2'h2
  } fcm_state_t;

endpackage

// [hw/fcm_sync3.sv]
// Three-stage synchroniser; output follows once stages two and three agree
// Assumes inputs asynchronous to clk
`timescale 1ns/1ps
module fcm_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule // fcm_sync3

// [hw/fcm_activity_det.sv]
// Flags a failure when the watched clock shows no edge in one sample window
// Assumes both clock inputs already synchronised to clk
`timescale 1ns/1ps
module fcm_activity_det #(
  parameter int SAMPLE_EDGES = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic mon_clk,
  input  wire logic ref_clk,
  output logic      fail
);
  localparam int CW = $clog2(SAMPLE_EDGES + 1);

  logic          mon_q;
  logic          ref_q;
  logic          seen;
  logic [CW-1:0] cnt;
  logic          next_seen;
  logic [CW-1:0] next_cnt;
  logic          next_fail;
  logic          tick;

  always_comb begin
    tick      = ref_clk & ~ref_q & (cnt == CW'(SAMPLE_EDGES - 1));
    next_cnt  = cnt;
    next_seen = seen;
    next_fail = 1'b0;
    if (!enable) begin
      next_cnt  = '0;
      next_seen = 1'b1;
    end else begin
      if (ref_clk && !ref_q) begin
        next_cnt = tick ? '0 : cnt + CW'(1);
      end
      if (tick) begin
        next_fail = ~seen & ~(mon_clk ^ mon_q);
        next_seen = 1'b0;
      end
      if (mon_clk ^ mon_q) begin
        next_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_q <= 1'b0;
      ref_q <= 1'b0;
      seen  <= 1'b1;
      cnt   <= '0;
      fail  <= 1'b0;
    end else begin
      mon_q <= mon_clk;
      ref_q <= ref_clk;
      seen  <= next_seen;
      cnt   <= next_cnt;
      fail  <= next_fail;
    end
  end
endmodule // fcm_activity_det

// [hw/fcm_top.sv]
// Fail-safe clock monitor: clock source selection, failure watch, APB registers
// Assumes MCLK at 25 MHz; oscillator and RC clock pins are asynchronous
//
// What this block does
// - On power-managed entry switch to the source the select field designates
// - Keep watching the power-managed source for failure
// - On failure with failure interrupt enabled, resume execution on internal oscillator
// - After failure stay on internal oscillator; never switch back by itself
// - With failure interrupt disabled, an interrupt in Idle resumes on internal oscillator
// - Failure can be detected after reset or wake once start-up is over; not during the start-up hold-off
// - External clock, external RC, internal RC modes: monitor at once
// - Crystal modes: run internal until start-up and PLL timers expire
// - Once primary is stable, the RC clock again paces the monitor
// - A primary that never starts raises no failure flag
// - Power-managed entry with a non-primary source selected while waiting for start-up disables the primary
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "fcm_consts.svh"
module fcm_top
  import fcm_pkg::*;
#(
  parameter int SAMPLE_EDGES = `FCM_SAMPLE_EDGES
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PRI_OSC_IN,
  input  wire logic        SEC_OSC_IN,
  input  wire logic        INTERNAL_RC_CLOCK,
  input  wire logic        OST_DONE,
  input  wire logic        PLL_DONE,
  input  wire logic        SLEEP_WAKE,
  input  wire logic        PM_ACTIVE,
  input  wire logic        IDLE_MODE,
  input  wire logic        OTHER_IRQ,
  output logic      [1:0]  CLK_SRC,
  output logic             PRI_OSC_EN,
  output logic             EXEC_RESUME,
  output logic             STARTUP_DONE,
  output logic             IRQ
);
  localparam int SW = `FCM_STAT_W;

  // Crystal and resonator modes need the start-up hold-off
  function automatic logic is_crystal(input logic [2:0] m);
    return (m == MD_LOW_POWER_XTAL) || (m == MD_STANDARD_XTAL) ||
           (m == MD_HIGH_SPEED_XTAL) || (m == MD_HIGH_SPEED_PLL);
  endfunction

  // Register state
  logic [2:0]    mode;
  logic [1:0]    sel;
  logic [SW-1:0] status;
  logic [SW-1:0] mask;
  logic [2:0]    next_mode;
  logic [1:0]    next_sel;
  logic [SW-1:0] next_status;
  logic [SW-1:0] next_mask;
  logic [31:0]   next_prdata;
  logic          next_pready;
  logic          next_pslverr;
  logic          next_irq;

  // Monitor state
  fcm_state_t    state;
  fcm_state_t    next_state;
  logic [1:0]    next_src;
  logic          next_pri_en;
  logic          next_resume;
  logic          next_done;
  logic          wait_irq;
  logic          next_wait_irq;
  logic          pm_q;
  logic          pm_enter;
  logic          set_fail;
  logic          set_ready;

  // Synchronised pins, detector and APB decode
  logic [2:0]    pins;
  logic          fail_pulse;
  logic          mon_en;
  logic          mon_clk;
  logic          apb_access;
  logic          apb_wr;
  logic          apb_rd;
  logic          addr_ok;

  fcm_sync3 #(
    .W(3)
  ) u_sync (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .din  ({INTERNAL_RC_CLOCK, SEC_OSC_IN, PRI_OSC_IN}),
    .dout (pins)
  );

  // Watched pin is the secondary pin when running from secondary, otherwise the primary pin
  assign mon_clk = (CLK_SRC == SRC_SECONDARY) ? pins[1] : pins[0];
  // Watch only a running non-internal source; no watch during start-up
  assign mon_en  = (state == ST_RUN) && (CLK_SRC != SRC_INTERNAL);

  fcm_activity_det #(
    .SAMPLE_EDGES(SAMPLE_EDGES)
  ) u_det (
    .clk     (MCLK),
    .rst     (SYS_RST),
    .enable  (mon_en),
    .mon_clk (mon_clk),
    .ref_clk (pins[2]),
    .fail    (fail_pulse)
  );

  // Entry is the rising edge, so a held request switches only once
  assign pm_enter = PM_ACTIVE & ~pm_q;

  // Monitor state machine
  always_comb begin
    next_state    = state;
    next_src      = CLK_SRC;
    next_pri_en   = PRI_OSC_EN;
    next_resume   = 1'b0;
    next_done     = STARTUP_DONE;
    next_wait_irq = wait_irq;
    set_fail      = 1'b0;
    set_ready     = 1'b0;
    unique case (state)
      ST_BOOT: begin
        // Reset mode is external clock; a crystal start needs a wake
        next_pri_en = 1'b1;
        if (is_crystal(mode)) begin
          next_state = ST_START;
          next_src   = SRC_INTERNAL;
          next_done  = 1'b0;
        end else begin
          next_state = ST_RUN;
          next_src   = SRC_PRIMARY;
          next_done  = 1'b1;
        end
      end
      ST_START: begin
        // Hold-off: internal clock until both timers report
        // A new power-managed source abandons the start-up
        if (pm_enter && sel != SRC_PRIMARY) begin
          next_state  = ST_RUN;
          next_src    = sel;
          next_pri_en = 1'b0;
        end else if (OST_DONE && PLL_DONE) begin
          next_state = ST_RUN;
          next_src   = SRC_PRIMARY;
          next_done  = 1'b1;
          // Start-up completion event for software
          set_ready  = 1'b1;
        end
      end
      ST_RUN: begin
        // A detector pulse outranks wake and power-managed entry
        if (fail_pulse) begin
          next_state = ST_FAIL;
          next_src   = SRC_INTERNAL;
          set_fail   = 1'b1;
          // Mask bit 0 doubles as the failure-interrupt enable
          if (mask[`FCM_STAT_FAIL]) begin
            next_resume = 1'b1;
          end else begin
            next_wait_irq = 1'b1;
          end
        end else if (SLEEP_WAKE && is_crystal(mode)) begin
          next_state  = ST_START;
          next_src    = SRC_INTERNAL;
          next_pri_en = 1'b1;
          next_done   = 1'b0;
        end else if (SLEEP_WAKE) begin
          next_src    = SRC_PRIMARY;
          next_pri_en = 1'b1;
          next_done   = 1'b1;
        end else if (pm_enter) begin
          next_src = sel;
          if (sel == SRC_PRIMARY) begin
            next_pri_en = 1'b1;
          end
        end
      end
      ST_FAIL: begin
        // Locked to the internal oscillator until reset
        next_src = SRC_INTERNAL;
        if (wait_irq && IDLE_MODE && OTHER_IRQ) begin
          next_resume   = 1'b1;
          next_wait_irq = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state        <= ST_BOOT;
      CLK_SRC      <= SRC_INTERNAL;
      PRI_OSC_EN   <= 1'b0;
      EXEC_RESUME  <= 1'b0;
      STARTUP_DONE <= 1'b0;
      wait_irq     <= 1'b0;
      pm_q         <= 1'b0;
    end else begin
      state        <= next_state;
      CLK_SRC      <= next_src;
      PRI_OSC_EN   <= next_pri_en;
      EXEC_RESUME  <= next_resume;
      STARTUP_DONE <= next_done;
      wait_irq     <= next_wait_irq;
      pm_q         <= PM_ACTIVE;
    end
  end

  // APB slave: one wait state, answer registered
  assign apb_access = PSEL & PENABLE & ~PREADY;
  assign apb_wr     = PSEL & PENABLE & PREADY & PWRITE;
  assign apb_rd     = apb_access & ~PWRITE;
  assign addr_ok    = (PADDR == `FCM_OFF_CTRL) || (PADDR == `FCM_OFF_STATUS) ||
                      (PADDR == `FCM_OFF_MASK) || (PADDR == `FCM_OFF_STATE);

  always_comb begin
    next_mode    = mode;
    next_sel     = sel;
    next_mask    = mask;
    next_status  = status;
    next_pready  = apb_access;
    next_pslverr = apb_access & ~addr_ok;
    next_prdata  = PRDATA;
    if (apb_wr && PADDR == `FCM_OFF_CTRL) begin
      next_mode = PWDATA[`FCM_CTRL_MODE_LSB +: 3];
      next_sel  = PWDATA[`FCM_CTRL_SEL_LSB +: 2];
    end
    if (apb_wr && PADDR == `FCM_OFF_MASK) begin
      next_mask = PWDATA[SW-1:0];
    end
    if (apb_wr && PADDR == `FCM_OFF_STATUS) begin
      next_status = status & ~PWDATA[SW-1:0];
    end
    // Hardware set wins over a clear in the same cycle
    if (set_fail) begin
      next_status[`FCM_STAT_FAIL] = 1'b1;
    end
    if (set_ready) begin
      next_status[`FCM_STAT_READY] = 1'b1;
    end
    // Read-back is registered so that it stands with PREADY
    if (apb_rd) begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR)
        `FCM_OFF_CTRL: begin
          next_prdata[`FCM_CTRL_MODE_LSB +: 3] = mode;
          next_prdata[`FCM_CTRL_SEL_LSB +: 2]  = sel;
        end
        `FCM_OFF_STATUS: begin
          next_prdata[SW-1:0] = status;
        end
        `FCM_OFF_MASK: begin
          next_prdata[SW-1:0] = mask;
        end
        `FCM_OFF_STATE: begin
          // Start-up status and monitor state for software polling
          next_prdata[0]   = STARTUP_DONE;
          next_prdata[2:1] = state;
          next_prdata[5:4] = CLK_SRC;
          next_prdata[6]   = PRI_OSC_EN;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
    // Taken from the next status so the line rises with the flag
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode    <= 3'(`FCM_CTRL_RESET);
      sel     <= 2'h0;
      status  <= '0;
      mask    <= `FCM_MASK_RESET;
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ     <= 1'b0;
    end else begin
      mode    <= next_mode;
      sel     <= next_sel;
      status  <= next_status;
      mask    <= next_mask;
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
      IRQ     <= next_irq;
    end
  end
endmodule // fcm_top

// [tb/fcm_properties.sv]
// Concurrent checks on the clock monitor top ports, bound into fcm_top
// Assumes one MCLK domain and SYS_RST asynchronous, active high
`timescale 1ns/1ps
`include "fcm_consts.svh"
module fcm_properties (
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        OST_DONE,
  input wire logic        PLL_DONE,
  input wire logic        PM_ACTIVE,
  input wire logic [1:0]  CLK_SRC,
  input wire logic        PRI_OSC_EN,
  input wire logic        EXEC_RESUME,
  input wire logic        STARTUP_DONE
);
  logic [1:0] sel;
  logic [1:0] next_sel;
  logic       failed;
  logic       next_failed;
  logic       starting;

  assign starting = !STARTUP_DONE && PRI_OSC_EN;
  // Shadow of the select field and of a reported failure
  always_comb begin
    next_sel    = sel;
    next_failed = failed | EXEC_RESUME;
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `FCM_OFF_CTRL) begin
      next_sel = PWDATA[5:4];
    end
  end
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sel    <= 2'h0;
      failed <= 1'b0;
    end else begin
      sel    <= next_sel;
      failed <= next_failed;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  AST_PM_ENTRY: assert property ($rose(PM_ACTIVE) && STARTUP_DONE && CLK_SRC != 2'h2
    |-> ##[1:3] CLK_SRC == sel) else $error("source not switched on entry");
  AST_START_INT: assert property (starting && !PM_ACTIVE |-> CLK_SRC == 2'h2)
    else $error("left internal source before start-up");
  AST_START_DONE: assert property (starting && OST_DONE && PLL_DONE && !PM_ACTIVE
    |-> ##[1:2] (STARTUP_DONE && CLK_SRC == 2'h0)) else $error("start-up not completed");
  AST_PM_DISABLE: assert property ($rose(PM_ACTIVE) && starting && sel != 2'h0
    |-> ##[1:3] !PRI_OSC_EN) else $error("primary kept enabled");
  AST_FAIL_STAYS: assert property (failed |-> CLK_SRC == 2'h2)
    else $error("switched back after failure");
  AST_RESUME_INT: assert property (EXEC_RESUME |-> CLK_SRC == 2'h2)
    else $error("resume not on internal source");
  AST_NO_FAIL_START: assert property (starting |-> !EXEC_RESUME)
    else $error("failure reported during start-up");
  AST_APB_WAIT: assert property ($rose(PENABLE) && PSEL |=> PREADY)
    else $error("access phase length wrong");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside completion");

  cover property (EXEC_RESUME);
  cover property ($rose(STARTUP_DONE));
  cover property ($rose(PM_ACTIVE) && starting);
endmodule // fcm_properties

bind fcm_top fcm_properties u_fcm_properties (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .OST_DONE(OST_DONE), .PLL_DONE(PLL_DONE), .PM_ACTIVE(PM_ACTIVE),
  .CLK_SRC(CLK_SRC), .PRI_OSC_EN(PRI_OSC_EN), .EXEC_RESUME(EXEC_RESUME),
  .STARTUP_DONE(STARTUP_DONE));

// [tb/fcm_osc_model.sv]
// Primary oscillator: toggles while enabled, prompt or slow rate
// Assumes stop models a dead crystal that holds its level
`timescale 1ns/1ps
module fcm_osc_model (
  input wire logic en,
  input wire logic stop,
  input wire logic slow,
  output logic     osc
);
  initial osc = 1'b0;
  always #(slow ? 390 : 130) if (en && !stop) osc = ~osc;
endmodule // fcm_osc_model

// [tb/testbench.sv]
// Self-checking bench: APB master, clock sources, start-up and failure cases
// Assumes fcm_top with a two-edge sample window
`timescale 1ns/1ps
`include "fcm_consts.svh"
module testbench
  import fcm_pkg::*;
;
  logic        MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, RC_CLK = 0;
  logic [7:0]  PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, r, v;
  logic [1:0]  CLK_SRC;
  logic        SEC_OSC_IN = 0, OST_DONE = 0, PLL_DONE = 0, SLEEP_WAKE = 0, PM_ACTIVE = 0;
  logic        IDLE_MODE = 0, OTHER_IRQ = 0, stop = 0, slow = 0, sec_run = 1, e;
  logic        PREADY, PSLVERR, PRI_OSC_IN, PRI_OSC_EN, EXEC_RESUME, STARTUP_DONE, IRQ;
  int          fails = 0, n_checks = 0, n_res = 0, cyc = 0, seed = 10423;

  always #20 MCLK = ~MCLK;
  always #235 RC_CLK = ~RC_CLK;
  always #110 if (sec_run) SEC_OSC_IN = ~SEC_OSC_IN;

  fcm_osc_model u_fcm_osc_model (.en(PRI_OSC_EN), .stop(stop), .slow(slow), .osc(PRI_OSC_IN));
  fcm_top #(.SAMPLE_EDGES(2)) u_fcm_top (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PRI_OSC_IN(PRI_OSC_IN), .SEC_OSC_IN(SEC_OSC_IN),
    .INTERNAL_RC_CLOCK(RC_CLK), .OST_DONE(OST_DONE), .PLL_DONE(PLL_DONE),
    .SLEEP_WAKE(SLEEP_WAKE), .PM_ACTIVE(PM_ACTIVE), .IDLE_MODE(IDLE_MODE),
    .OTHER_IRQ(OTHER_IRQ), .CLK_SRC(CLK_SRC), .PRI_OSC_EN(PRI_OSC_EN),
    .EXEC_RESUME(EXEC_RESUME), .STARTUP_DONE(STARTUP_DONE), .IRQ(IRQ));

  always @(posedge MCLK) begin
    cyc++;
    if (EXEC_RESUME === 1'b1) n_res++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task cb(input logic x, input logic g);
    chk({31'h0, x}, {31'h0, g});
  endtask
  task cs(input logic [1:0] x);
    chk({30'h0, x}, {30'h0, CLK_SRC});
  endtask
  task tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1;
    // PREADY ends the wait for the answer; with no timeout of its own, only the cycle ceiling stops a hung one
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(x, r);
  endtask
  task pulse_wake;
    @(posedge MCLK);
    SLEEP_WAKE <= 1;
    @(posedge MCLK);
    SLEEP_WAKE <= 0;
  endtask
  task wres(input int lim);
    int k;
    k = n_res;
    repeat (lim) if (n_res == k) @(posedge MCLK);
    #1;
    cb(1'b1, n_res != k);
  endtask
  task rst;
    SYS_RST = 1;
    {OST_DONE, PLL_DONE, PM_ACTIVE, IDLE_MODE, OTHER_IRQ} = 0;
    repeat (5) @(posedge MCLK);
    SYS_RST <= 0;
    tick(1);
  endtask
  function logic [31:0] stw(logic d, logic [1:0] s, logic [1:0] c, logic en);
    return {25'h0, en, c, 1'b0, s, d};
  endfunction
  function logic [31:0] ctl(logic [1:0] s, logic [2:0] m);
    return {26'h0, s, 1'b0, m};
  endfunction

  initial begin
    rst;
    rc(`FCM_OFF_STATE, stw(1'b1, ST_RUN, SRC_PRIMARY, 1'b1));
    rc(`FCM_OFF_MASK, 32'h0);
    rc(8'h10, 32'h0);
    cb(1'b1, e);
    repeat (6) begin
      v = $random(seed);
      apb(1'b1, `FCM_OFF_CTRL, v);
      rc(`FCM_OFF_CTRL, v & 32'h37);
      apb(1'b1, `FCM_OFF_MASK, v);
      rc(`FCM_OFF_MASK, v & 32'h3);
    end
    apb(1'b1, `FCM_OFF_MASK, 32'h0);
    slow = 1;
    tick(300);
    rc(`FCM_OFF_STATUS, 32'h0);
    slow = 0;
    $display("test registers done");
    apb(1'b1, `FCM_OFF_CTRL, ctl(SRC_PRIMARY, MD_STANDARD_XTAL));
    pulse_wake;
    stop = 1;
    tick(2);
    cs(SRC_INTERNAL);
    tick(300);
    rc(`FCM_OFF_STATUS, 32'h0);
    rc(`FCM_OFF_STATE, stw(1'b0, ST_START, SRC_INTERNAL, 1'b1));
    stop = 0;
    repeat ($random(seed) & 15) @(posedge MCLK);
    OST_DONE <= 1;
    tick(5);
    cb(1'b0, STARTUP_DONE);
    @(posedge MCLK);
    PLL_DONE <= 1;
    tick(3);
    rc(`FCM_OFF_STATE, stw(1'b1, ST_RUN, SRC_PRIMARY, 1'b1));
    rc(`FCM_OFF_STATUS, 32'h2);
    stop = 1;
    tick(300);
    cs(SRC_INTERNAL);
    cb(1'b0, n_res != 0);
    @(posedge MCLK);
    {IDLE_MODE, OTHER_IRQ} <= 2'b11;
    wres(20);
    cb(1'b0, IRQ);
    rc(`FCM_OFF_STATUS, 32'h3);
    stop = 0;
    tick(100);
    cs(SRC_INTERNAL);
    $display("test crystal start and failure done");
    rst;
    apb(1'b1, `FCM_OFF_CTRL, ctl(SRC_SECONDARY, MD_HIGH_SPEED_PLL));
    pulse_wake;
    repeat (3) @(posedge MCLK);
    PM_ACTIVE <= 1;
    tick(4);
    cb(1'b0, PRI_OSC_EN);
    cs(SRC_SECONDARY);
    apb(1'b1, `FCM_OFF_CTRL, ctl(SRC_SECONDARY, MD_INTERNAL_RC));
    PM_ACTIVE <= 0;
    pulse_wake;
    tick(2);
    cs(SRC_PRIMARY);
    cb(1'b1, STARTUP_DONE);
    $display("test mode change during start-up done");
    rst;
    apb(1'b1, `FCM_OFF_MASK, 32'h1);
    apb(1'b1, `FCM_OFF_CTRL, ctl(SRC_SECONDARY, MD_EXTERNAL_CLOCK));
    @(posedge MCLK);
    PM_ACTIVE <= 1;
    tick(4);
    cs(SRC_SECONDARY);
    sec_run = 0;
    wres(300);
    cs(SRC_INTERNAL);
    tick(2);
    cb(1'b1, IRQ);
    sec_run = 1;
    pulse_wake;
    tick(100);
    cs(SRC_INTERNAL);
    apb(1'b1, `FCM_OFF_STATUS, 32'h1);
    tick(3);
    cb(1'b0, IRQ);
    $display("test power-managed failure done");
    finish_test;
  end
endmodule // testbench
